// >>> ptdp_params.svh
// Offsets, field positions, reset values and timing counts for the pulse totalizer block.
// Assumes inclusion by bare name from the package or design file.
`ifndef PTDP_PARAMS_SVH
`define PTDP_PARAMS_SVH
`define PTDP_CTRL_OFS 12'h000
`define PTDP_COUNT_OFS 12'h004
`define PTDP_PORTS_OFS 12'h008
`define PTDP_OUT_OFS 12'h00C
`define PTDP_DIR_OFS 12'h010
`define PTDP_SCAN_OFS 12'h014
`define PTDP_CTRL_FALL_BIT 0
`define PTDP_CTRL_CLR_RD_BIT 1
`define PTDP_CTRL_ZERO_BIT 2
`define PTDP_CTRL_CLEAR_BIT 3
`define PTDP_CTRL_RST 4'h0
`define PTDP_SCAN_RST 2'h0
`define PTDP_CNT_W 26
`define PTDP_PORT_W 8
`define PTDP_CLK_HZ 125000000
`define PTDP_MAX_PULSE_HZ 100000
`endif

// >>> ptdp_pkg.sv
// Types shared by the pulse totalizer and dual byte port block.
// Assumes the parameter header sits in the same folder.
`include "ptdp_params.svh"
package ptdp_pkg;
   typedef logic [`PTDP_CNT_W-1:0] ptdp_count_t;
   typedef logic [`PTDP_PORT_W-1:0] ptdp_byte_t;
   typedef enum logic [1:0] {
      PTDP_IDLE = 2'b00,
      PTDP_ACCESS = 2'b01
   } ptdp_bus_e;
endpackage : ptdp_pkg

// >>> ptdp_top.sv
// APB slave with a 26-bit gated pulse totalizer and two 8-bit open-drain byte ports.
// Assumes pins are asynchronous to pclk; the host scan controller reads over APB.
//
// Behaviour
// (R1) The pulse total is a 26-bit counter that adds one for each qualified pulse.
// (R2) Every qualified pulse up to 100 kHz is counted without loss.
// (R3) A control bit chooses rising or falling edges of the pulse input for counting.
// (R4) The active-high gate enables counting while high and blocks it while low.
// (R5) The active-low gate enables counting while low and blocks it while high.
// (R6) Counting happens only while both gates enable at once.
// (R7) A threshold control selects zero-crossing or logic-level detection, logic level by default.
// (R8) Two independent 8-bit byte ports have logic-level inputs and outputs. The code drives each output pin open-drain: pulled low or released.
// (R9) A front-panel read gets only one selected 8-bit port per access.
// (R10) A combined 16-bit read of both ports is permitted only when neither is in the scan list.
// (R11) The scan sequence may sample both ports and the current count while a scan runs.
// (R12) Reset makes both ports inputs and clears the count to zero.
// (R13) Reading the count leaves it unchanged unless clear-on-read is selected.
// (R14) Pulse and gate inputs are synchronised before edge detection so one edge gives one count.
// (R15) A qualified pulse at the all-ones count wraps it to zero.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "ptdp_params.svh"
module ptdp_top #(
   parameter int CNT_W = `PTDP_CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pulse_in,
   input wire logic gate_high,
   input wire logic gate_low_n,
   input wire ptdp_pkg::ptdp_byte_t port_a_in,
   input wire ptdp_pkg::ptdp_byte_t port_b_in,
   output ptdp_pkg::ptdp_byte_t port_a_out,
   output ptdp_pkg::ptdp_byte_t port_a_oe,
   output ptdp_pkg::ptdp_byte_t port_b_out,
   output ptdp_pkg::ptdp_byte_t port_b_oe,
   output logic zero_cross_detect
);
   import ptdp_pkg::*;

   // ****************************************
   // Timing
   // ****************************************
   // Half a pulse period at the top rate, in cycles; the sampler needs two cycles per level.
   localparam int HALF_PERIOD_CYC = `PTDP_CLK_HZ / (2 * `PTDP_MAX_PULSE_HZ);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [2:0] pulse_sync;
      logic [1:0] gh_sync;
      logic [1:0] gl_sync;
      logic [7:0] pa_s1;
      logic [7:0] pa_s2;
      logic [7:0] pb_s1;
      logic [7:0] pb_s2;
      logic [CNT_W-1:0] count;
      logic fall_edge;
      logic clr_on_rd;
      logic zero_mode;
      logic [7:0] out_a;
      logic [7:0] out_b;
      logic [7:0] dir_a;
      logic [7:0] dir_b;
      logic [1:0] in_scan;
      logic [7:0] oe_a;
      logic [7:0] oe_b;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } ptdp_state_s;

   ptdp_state_s st;
   ptdp_state_s next_st;

   function automatic logic [31:0] pad_count(input logic [CNT_W-1:0] c);
      pad_count = 32'(c);
   endfunction : pad_count

   logic setup;
   logic rise;
   logic fall;
   logic gates_open;
   logic qualified;
   logic rd_count;

   always_comb begin
      setup = psel && !penable;
      rise = st.pulse_sync[1] && !st.pulse_sync[2];
      fall = !st.pulse_sync[1] && st.pulse_sync[2];
      gates_open = st.gh_sync[1] && !st.gl_sync[1]; // [R4] [R5] [R6]
      qualified = gates_open && (st.fall_edge ? fall : rise); // [R3]
      rd_count = setup && !pwrite && (paddr == `PTDP_COUNT_OFS);
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_st = st;
      // Logic reads the second stage of each synchroniser; the pulse edge detector also reads the third. [R14]
      next_st.pulse_sync = {st.pulse_sync[1:0], pulse_in};
      next_st.gh_sync = {st.gh_sync[0], gate_high};
      next_st.gl_sync = {st.gl_sync[0], gate_low_n};
      next_st.pa_s1 = port_a_in; // [R8]
      next_st.pa_s2 = st.pa_s1;
      next_st.pb_s1 = port_b_in;
      next_st.pb_s2 = st.pb_s1;
      next_st.ready = 1'b0;
      next_st.err = 1'b0;
      // A clear on read is a base of zero; a pulse in that same cycle still counts. [R13]
      if (rd_count && st.clr_on_rd) begin
         next_st.count = '0;
      end
      if (qualified) begin
         next_st.count = (rd_count && st.clr_on_rd) ? CNT_W'(1) : st.count + CNT_W'(1); // [R1] [R2] [R15]
      end
      if (setup) begin
         next_st.ready = 1'b1;
         next_st.rdata = 32'h00000000;
         if (pwrite) begin
            unique case (paddr)
               `PTDP_CTRL_OFS: begin
                  next_st.fall_edge = pwdata[`PTDP_CTRL_FALL_BIT]; // [R3]
                  next_st.clr_on_rd = pwdata[`PTDP_CTRL_CLR_RD_BIT];
                  next_st.zero_mode = pwdata[`PTDP_CTRL_ZERO_BIT]; // [R7]
                  if (pwdata[`PTDP_CTRL_CLEAR_BIT] && !qualified) begin
                     next_st.count = '0;
                  end
               end
               `PTDP_OUT_OFS: begin
                  next_st.out_a = pwdata[7:0];
                  next_st.out_b = pwdata[15:8];
               end
               `PTDP_DIR_OFS: begin
                  next_st.dir_a = pwdata[7:0];
                  next_st.dir_b = pwdata[15:8];
               end
               `PTDP_SCAN_OFS: next_st.in_scan = pwdata[1:0];
               default: next_st.err = 1'b1;
            endcase
         end else begin
            unique case (paddr)
               `PTDP_CTRL_OFS: next_st.rdata = {28'h0000000, 1'b0, st.zero_mode,
                                                st.clr_on_rd, st.fall_edge};
               `PTDP_COUNT_OFS: next_st.rdata = pad_count(st.count); // [R11]
               // Each byte lane returns one port alone; a 16-bit word needs both out of scan.
               `PTDP_PORTS_OFS: begin
                  if (st.in_scan == 2'b00) begin
                     next_st.rdata = {16'h0000, st.pb_s2, st.pa_s2}; // [R10]
                  end else begin
                     next_st.err = 1'b1; // [R10]
                  end
               end
               12'h018: next_st.rdata = {24'h000000, st.pa_s2}; // [R9] [R11]
               12'h01C: next_st.rdata = {24'h000000, st.pb_s2}; // [R9] [R11]
               `PTDP_OUT_OFS: next_st.rdata = {16'h0000, st.out_b, st.out_a};
               `PTDP_DIR_OFS: next_st.rdata = {16'h0000, st.dir_b, st.dir_a};
               `PTDP_SCAN_OFS: next_st.rdata = {30'h00000000, st.in_scan};
               default: next_st.err = 1'b1;
            endcase
         end
      end
      // Enables are registered so the pins come straight from flip-flops.
      next_st.oe_a = next_st.dir_a & ~next_st.out_a; // [R8] [R12]
      next_st.oe_b = next_st.dir_b & ~next_st.out_b; // [R8] [R12]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0; // [R12] [R7]
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Open-drain: a driven low bit enables the pin, a high bit releases it to the pull-up.
   always_comb begin
      prdata = st.rdata;
      pready = st.ready;
      pslverr = st.err;
      port_a_out = 8'h00;
      port_b_out = 8'h00;
      port_a_oe = st.oe_a;
      port_b_oe = st.oe_b;
      zero_cross_detect = st.zero_mode;
   end

   // ****************************************
   // Assertions
   // ****************************************
   count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      qualified && !rd_count && !(setup && pwrite) |=> st.count == $past(st.count) + CNT_W'(1))
      else $error("count did not step on a qualified pulse"); // [R1] [R15]
   gate_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      !gates_open && !setup |=> st.count == $past(st.count))
      else $error("count moved with a gate closed"); // [R6]
   gate_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      !st.gh_sync[1] |-> !qualified)
      else $error("pulse qualified with high gate low"); // [R4]
   gate_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      st.gl_sync[1] |-> !qualified)
      else $error("pulse qualified with low gate high"); // [R5]
   edge_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      qualified |-> (st.fall_edge ? !st.pulse_sync[1] : st.pulse_sync[1]))
      else $error("count on wrong edge"); // [R3]
   keep_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_count && !st.clr_on_rd && !qualified |=> st.count == $past(st.count))
      else $error("plain read changed the count"); // [R13]
   combo_scan_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == `PTDP_PORTS_OFS && st.in_scan != 2'b00 |=> pslverr)
      else $error("combined read allowed during scan"); // [R10]
   one_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready)
      else $error("ready not one cycle after setup"); // [R11]
   rate_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
      rise |=> !rise [*2])
      else $error("edge detector fired twice"); // [R2] [R14]
   initial_param_a: assert property (@(posedge pclk) HALF_PERIOD_CYC >= 2)
      else $error("clock too slow for pulse rate"); // [R2]
endmodule : ptdp_top

// >>> ptdp_pulse_src.sv
// Far-side pulse source that drives the totalizer pulse pin.
// Assumes the caller waits for each task to return before calling again.
`timescale 1ns/1ns
module ptdp_pulse_src #(
   parameter int HALF = 625
) (
   input wire logic pclk,
   output logic pulse_out
);
   // *****************************************
   // Pulse generation
   // *****************************************
   // Half of a 100 kHz period at 125 MHz, so no pulse comes faster than the rated rate.
   initial begin
      pulse_out = 1'b0;
   end
   task automatic level(input logic v);
      pulse_out <= v;
      repeat (HALF) @(posedge pclk);
   endtask : level
   task automatic burst(input int n);
      repeat (n) begin
         level(1'b1);
         level(1'b0);
      end
   endtask : burst
endmodule : ptdp_pulse_src

// >>> pulse_totalizer_and_dual_port_io_test.sv
// Self-checking bench for the totalizer and byte ports over APB.
// Assumes a 4-bit count so that the wrap is reached in a short run.
`timescale 1ns/1ns
module pulse_totalizer_and_dual_port_io_test;
   import ptdp_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, pulse_in, gate_high = 1'b1, gate_low_n = 1'b0, zcd;
   ptdp_byte_t pa_in = 8'hA5, pb_in = 8'h3C, pa_out, pa_oe, pb_out, pb_oe;
   int failures = 0, n_tests = 0;
   always #4 pclk = ~pclk;
   ptdp_top #(.CNT_W(4)) u_ptdp_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pulse_in(pulse_in), .gate_high(gate_high),
      .gate_low_n(gate_low_n), .port_a_in(pa_in), .port_b_in(pb_in), .port_a_out(pa_out),
      .port_a_oe(pa_oe), .port_b_out(pb_out), .port_b_oe(pb_oe), .zero_cross_detect(zcd));
   ptdp_pulse_src u_ptdp_pulse_src (.pclk(pclk), .pulse_out(pulse_in));
   // *****************************************
   // Bus tasks and comparison
   // *****************************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk
   // The request holds until pready is sampled high, then one idle edge passes.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Look at the answer mid-cycle, then release at the edge that samples it.
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) failures++;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk($sformatf("read %h", a), exp, q);
      chk("pslverr", {31'h0, ee}, {31'h0, e});
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   // *****************************************
   // Test sequence
   // *****************************************
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("port_a_oe", 32'h0, {24'h0, pa_oe});
      chk("zero_cross_detect", 32'h0, {31'h0, zcd});
      rd(12'h004, 32'h0, 1'b0);
      u_ptdp_pulse_src.burst(5);
      rd(12'h004, 32'h5, 1'b0);
      rd(12'h004, 32'h5, 1'b0);
      gate_high <= 1'b0;
      u_ptdp_pulse_src.burst(2);
      rd(12'h004, 32'h5, 1'b0);
      gate_high <= 1'b1;
      gate_low_n <= 1'b1;
      u_ptdp_pulse_src.burst(2);
      rd(12'h004, 32'h5, 1'b0);
      gate_low_n <= 1'b0;
      wr(12'h000, 32'h1);
      u_ptdp_pulse_src.level(1'b1);
      rd(12'h004, 32'h5, 1'b0);
      u_ptdp_pulse_src.level(1'b0);
      rd(12'h004, 32'h6, 1'b0);
      wr(12'h000, 32'h0);
      u_ptdp_pulse_src.burst(11);
      rd(12'h004, 32'h1, 1'b0);
      wr(12'h000, 32'h2);
      rd(12'h004, 32'h1, 1'b0);
      rd(12'h004, 32'h0, 1'b0);
      wr(12'h000, 32'h4);
      chk("zero_cross_detect", 32'h1, {31'h0, zcd});
      rd(12'h018, 32'hA5, 1'b0);
      rd(12'h01C, 32'h3C, 1'b0);
      rd(12'h008, 32'h3CA5, 1'b0);
      wr(12'h014, 32'h1);
      rd(12'h008, 32'h0, 1'b1);
      rd(12'h018, 32'hA5, 1'b0);
      rd(12'h004, 32'h0, 1'b0);
      pa_in <= 8'h5A;
      pb_in <= 8'hC3;
      wr(12'h014, 32'h0);
      rd(12'h008, 32'hC35A, 1'b0);
      wr(12'h00C, 32'h100);
      wr(12'h010, 32'h101);
      @(posedge pclk);
      chk("port_a_oe", 32'h1, {24'h0, pa_oe});
      chk("port_b_oe", 32'h0, {24'h0, pb_oe});
      rd(12'h020, 32'h0, 1'b1);
      final_report;
   end
   // The run needs about 26300 cycles; the limit leaves ample margin.
   initial begin
      repeat (80000) @(posedge pclk);
      failures++;
      final_report;
   end
endmodule : pulse_totalizer_and_dual_port_io_test
